// ===== rtl/timer_dma_channels.sv
// Timer compare-0 and capture-0 DMA channels with their data registers
// Contract
// - Each internal transaction is one 16-bit word, two byte transfers back to back.
// - Second byte requests at priority 000; programmed level returns afterwards.
// - A started word keeps its channel ahead of the other until both bytes move.
// - Terminal count on the last byte ends the block and signals end-of-block.
// - In swap mode every end-of-block inverts the channel's pointer select bit 2.
// - Compare select is counter base bit 2, capture select address base bit 2.
// - Pointer addresses use only the select bit of the channel being served.
// - One swap enable bit switches swap mode for both channels together.
// - End-of-block interrupt at channel priority, only without DMA request or overflow.
// - Software may write end-of-block flags; a one with request enable raises interrupt.
// - End-of-block while its flag is still set clears that channel's DMA mask.
// - External mode moves one byte per request.
// - Compare external mode outputs memory to port on compare or software request.
// - Compare external mode strobes the port, optionally with the event pulse.
// - Capture external mode direction follows the port's DMA direction bit.
// - Capture external request from input A capture or software; sync pulse given.
// - Linked input A with toggled output gives a capture request per compare event, in capture external mode with compare external mode off.
// - Capture/load pairs hold 16 bits, capture counter or preload it.
// - Compare pairs hold 16 bits compared with the counter.
// - Timer control resets upper five bits to zero, lower three are status.
// - Memory mode pointer address bit 1 is zero for capture, one for compare.
// - Capture channel wins over compare channel when both request.
// - An event while its pending flag is set sets the overrun flag.
`include "timer_dma_map.svh"
module timer_dma_channels import timer_dma_pkg::*; (
	input wire logic clk,
	input wire logic rst,
	input wire logic reg_page_dma,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	input wire logic compare_zero_event,
	input wire logic capture_zero_event,
	input wire logic capture_one_event,
	input wire logic [15:0] capture_value,
	input wire logic over_under_flow_event,
	input wire logic [2:0] timer_status,
	input wire logic cmp_to_cap_link,
	input wire logic port_dma_direction,
	input wire logic dma_ack,
	input wire logic dma_last,
	input wire logic [7:0] dma_wdata,
	output logic dma_req,
	output logic [2:0] dma_prio,
	output logic dma_chan_cap,
	output logic dma_to_mem,
	output logic dma_byte_mode,
	output logic [7:0] dma_cnt_ptr,
	output logic [7:0] dma_addr_ptr,
	output logic [7:0] dma_rdata,
	output logic irq_req,
	output logic [2:0] irq_prio,
	output logic port_strobe,
	output logic port_event_pulse,
	output logic port_sync,
	output logic [7:0] port_data,
	output logic [15:0] compare0_value,
	output logic [15:0] compare1_value,
	output logic [15:0] load0_value,
	output logic [15:0] load1_value,
	output logic [4:0] timer_control_bits
);
	dma_state_t st;
	dma_state_t next_st;
	logic fin;
	logic fin_eob;
	logic cap_ev;

	function automatic logic hit(input logic page, input logic [7:0] addr, input logic want_page,
		input logic [7:0] ofs);
		hit = (page == want_page) && (addr == ofs);
	endfunction

	// ==========================================
	// Next state
	always_comb begin
		logic [7:0] ctl;
		logic [7:0] msk;
		logic sel;
		logic chb;
		logic cap_ext;
		logic cmp_ext;
		ctl = 8'h00;
		msk = 8'h00;
		sel = 1'b0;
		chb = 1'b0;
		cap_ext = 1'b0;
		cmp_ext = 1'b0;
		next_st = st;
		fin = 1'b0;
		fin_eob = 1'b0;
		next_st.port_strobe = 1'b0;
		next_st.port_event_pulse = 1'b0;
		next_st.port_sync = 1'b0;
		cap_ext = st.int_dma_control_reg[`CTL_CAP_EXT];
		cmp_ext = st.int_dma_control_reg[`CTL_CMP_EXT];
		cap_ev = capture_zero_event | (compare_zero_event & cmp_to_cap_link & cap_ext & ~cmp_ext);

		// Register writes
		if (reg_wr) begin
			if (hit(reg_page_dma, reg_addr, 1'b0, `OFS_CAPTURE_LOAD0_HIGH)) begin
				next_st.capture_load0_pair[15:8] = reg_wdata;
			end else if (hit(reg_page_dma, reg_addr, 1'b0, `OFS_CAPTURE_LOAD0_LOW)) begin
				next_st.capture_load0_pair[7:0] = reg_wdata;
			end else if (hit(reg_page_dma, reg_addr, 1'b0, `OFS_CAPTURE_LOAD1_HIGH)) begin
				next_st.capture_load1_pair[15:8] = reg_wdata;
			end else if (hit(reg_page_dma, reg_addr, 1'b0, `OFS_CAPTURE_LOAD1_LOW)) begin
				next_st.capture_load1_pair[7:0] = reg_wdata;
			end else if (hit(reg_page_dma, reg_addr, 1'b0, `OFS_COMPARE0_HIGH)) begin
				next_st.compare0_pair[15:8] = reg_wdata;
			end else if (hit(reg_page_dma, reg_addr, 1'b0, `OFS_COMPARE0_LOW)) begin
				next_st.compare0_pair[7:0] = reg_wdata;
			end else if (hit(reg_page_dma, reg_addr, 1'b0, `OFS_COMPARE1_HIGH)) begin
				next_st.compare1_pair[15:8] = reg_wdata;
			end else if (hit(reg_page_dma, reg_addr, 1'b0, `OFS_COMPARE1_LOW)) begin
				next_st.compare1_pair[7:0] = reg_wdata;
			end else if (hit(reg_page_dma, reg_addr, 1'b0, `OFS_TIMER_CONTROL)) begin
				next_st.timer_control = reg_wdata[7:3];
			end else if (hit(reg_page_dma, reg_addr, 1'b0, `OFS_TIMER_FLAG)) begin
				next_st.timer_flag_reg = reg_wdata[3:0];
			end else if (hit(reg_page_dma, reg_addr, 1'b0, `OFS_INT_DMA_MASK)) begin
				next_st.int_dma_mask_reg = reg_wdata;
			end else if (hit(reg_page_dma, reg_addr, 1'b1, `OFS_COUNTER_POINTER_BASE)) begin
				next_st.counter_pointer_base = reg_wdata;
			end else if (hit(reg_page_dma, reg_addr, 1'b1, `OFS_ADDRESS_POINTER_BASE)) begin
				next_st.address_pointer_base = reg_wdata;
			end else if (hit(reg_page_dma, reg_addr, 1'b1, `OFS_INT_DMA_CONTROL)) begin
				next_st.int_dma_control_reg[5:0] = reg_wdata[5:0];
				// Flag takes a one only with request enable, a zero always
				next_st.int_dma_control_reg[`CTL_EOB_CAP] = reg_wdata[`CTL_EOB_CAP] &
					(st.int_dma_mask_reg[`MSK_SW_REQ_EN] | st.int_dma_control_reg[`CTL_EOB_CAP]);
				next_st.int_dma_control_reg[`CTL_EOB_CMP] = reg_wdata[`CTL_EOB_CMP] &
					(st.int_dma_mask_reg[`MSK_SW_REQ_EN] | st.int_dma_control_reg[`CTL_EOB_CMP]);
			end
		end

		// Transfer sequencer
		case (st.phase)
			PH_IDLE: begin
				if (st.timer_flag_reg[`FLG_PEND_CAP] && st.int_dma_mask_reg[`MSK_DMA_CAP]) begin
					next_st.phase = PH_BYTE_FIRST;
					next_st.chan_cap = 1'b1;
					next_st.word = ~cap_ext;
				end else if (st.timer_flag_reg[`FLG_PEND_CMP] && st.int_dma_mask_reg[`MSK_DMA_CMP]) begin
					next_st.phase = PH_BYTE_FIRST;
					next_st.chan_cap = 1'b0;
					next_st.word = ~cmp_ext;
				end
			end
			PH_BYTE_FIRST: begin
				if (dma_ack) begin
					if (!st.chan_cap && st.word) begin
						next_st.compare0_pair[15:8] = dma_wdata;
					end
					if (!st.chan_cap && !st.word) begin
						next_st.port_data = dma_wdata;
						next_st.port_strobe = 1'b1;
						next_st.port_event_pulse = st.int_dma_mask_reg[`MSK_EVENT_PULSE];
					end
					if (st.chan_cap && !st.word) begin
						next_st.port_sync = 1'b1;
					end
					if (st.word) begin
						next_st.phase = PH_BYTE_SECOND;
					end else begin
						fin = 1'b1;
					end
				end
			end
			PH_BYTE_SECOND: begin
				if (dma_ack) begin
					if (!st.chan_cap) begin
						next_st.compare0_pair[7:0] = dma_wdata;
					end
					fin = 1'b1;
				end
			end
			default: begin
				next_st.phase = PH_IDLE;
			end
		endcase

		// Completion, end of block and protection
		if (fin) begin
			next_st.phase = PH_IDLE;
			if (st.chan_cap) begin
				next_st.timer_flag_reg[`FLG_PEND_CAP] = 1'b0;
			end else begin
				next_st.timer_flag_reg[`FLG_PEND_CMP] = 1'b0;
			end
			if (dma_last) begin
				fin_eob = 1'b1;
				if (st.chan_cap) begin
					if (st.int_dma_control_reg[`CTL_EOB_CAP]) begin
						next_st.int_dma_mask_reg[`MSK_DMA_CAP] = 1'b0;
					end
					next_st.int_dma_control_reg[`CTL_EOB_CAP] = 1'b1;
					if (st.int_dma_control_reg[`CTL_SWAP_EN]) begin
						next_st.address_pointer_base[`PTR_SWAP_BIT] = ~st.address_pointer_base[`PTR_SWAP_BIT];
					end
				end else begin
					if (st.int_dma_control_reg[`CTL_EOB_CMP]) begin
						next_st.int_dma_mask_reg[`MSK_DMA_CMP] = 1'b0;
					end
					next_st.int_dma_control_reg[`CTL_EOB_CMP] = 1'b1;
					if (st.int_dma_control_reg[`CTL_SWAP_EN]) begin
						next_st.counter_pointer_base[`PTR_SWAP_BIT] = ~st.counter_pointer_base[`PTR_SWAP_BIT];
					end
				end
			end
		end

		// Timer events, set wins over clear
		if (compare_zero_event) begin
			if (st.timer_flag_reg[`FLG_PEND_CMP]) begin
				next_st.timer_flag_reg[`FLG_OVR_CMP] = 1'b1;
			end
			next_st.timer_flag_reg[`FLG_PEND_CMP] = 1'b1;
		end
		if (cap_ev) begin
			if (st.timer_flag_reg[`FLG_PEND_CAP]) begin
				next_st.timer_flag_reg[`FLG_OVR_CAP] = 1'b1;
			end
			next_st.timer_flag_reg[`FLG_PEND_CAP] = 1'b1;
		end
		if (capture_zero_event) begin
			next_st.capture_load0_pair = capture_value;
		end
		if (capture_one_event) begin
			next_st.capture_load1_pair = capture_value;
		end

		// DMA port outputs
		ctl = next_st.int_dma_control_reg;
		msk = next_st.int_dma_mask_reg;
		next_st.dma_req = (next_st.phase != PH_IDLE);
		next_st.dma_prio = (next_st.phase == PH_BYTE_SECOND) ? `PRIO_TOP : ctl[`CTL_PRIO_HI:0];
		sel = next_st.chan_cap ? next_st.address_pointer_base[`PTR_SWAP_BIT] :
			next_st.counter_pointer_base[`PTR_SWAP_BIT];
		chb = ~next_st.chan_cap;
		if (next_st.counter_pointer_base[`PTR_REG_TO_REG]) begin
			next_st.dma_cnt_ptr = {next_st.counter_pointer_base[7:3], sel, chb, 1'b1};
			next_st.dma_addr_ptr = {next_st.counter_pointer_base[7:3], sel, chb, 1'b0};
		end else begin
			next_st.dma_cnt_ptr = {next_st.counter_pointer_base[7:3], sel, chb, 1'b0};
			next_st.dma_addr_ptr = {next_st.address_pointer_base[7:3], sel, chb, 1'b0};
		end
		next_st.dma_to_mem = next_st.chan_cap &
			(~ctl[`CTL_CAP_EXT] | port_dma_direction);
		next_st.dma_rdata = (next_st.phase == PH_BYTE_SECOND) ? next_st.capture_load0_pair[7:0] :
			next_st.capture_load0_pair[15:8];

		// End-of-block and event interrupts
		next_st.irq_req = 1'b0;
		next_st.irq_prio = `PRIO_COMPARE;
		if (msk[`MSK_GLOBAL] && !next_st.dma_req && !over_under_flow_event) begin
			if (ctl[`CTL_EOB_CAP] || (next_st.timer_flag_reg[`FLG_PEND_CAP] && !msk[`MSK_DMA_CAP] &&
				msk[`MSK_INT_CAP])) begin
				next_st.irq_req = 1'b1;
				next_st.irq_prio = `PRIO_CAPTURE;
			end else if (ctl[`CTL_EOB_CMP] || (next_st.timer_flag_reg[`FLG_PEND_CMP] &&
				!msk[`MSK_DMA_CMP] && msk[`MSK_INT_CMP])) begin
				next_st.irq_req = 1'b1;
				next_st.irq_prio = `PRIO_COMPARE;
			end
		end

		// Register reads
		next_st.reg_rdata = `RESET_BYTE;
		if (reg_rd) begin
			if (hit(reg_page_dma, reg_addr, 1'b0, `OFS_CAPTURE_LOAD0_HIGH)) begin
				next_st.reg_rdata = st.capture_load0_pair[15:8];
			end else if (hit(reg_page_dma, reg_addr, 1'b0, `OFS_CAPTURE_LOAD0_LOW)) begin
				next_st.reg_rdata = st.capture_load0_pair[7:0];
			end else if (hit(reg_page_dma, reg_addr, 1'b0, `OFS_CAPTURE_LOAD1_HIGH)) begin
				next_st.reg_rdata = st.capture_load1_pair[15:8];
			end else if (hit(reg_page_dma, reg_addr, 1'b0, `OFS_CAPTURE_LOAD1_LOW)) begin
				next_st.reg_rdata = st.capture_load1_pair[7:0];
			end else if (hit(reg_page_dma, reg_addr, 1'b0, `OFS_COMPARE0_HIGH)) begin
				next_st.reg_rdata = st.compare0_pair[15:8];
			end else if (hit(reg_page_dma, reg_addr, 1'b0, `OFS_COMPARE0_LOW)) begin
				next_st.reg_rdata = st.compare0_pair[7:0];
			end else if (hit(reg_page_dma, reg_addr, 1'b0, `OFS_COMPARE1_HIGH)) begin
				next_st.reg_rdata = st.compare1_pair[15:8];
			end else if (hit(reg_page_dma, reg_addr, 1'b0, `OFS_COMPARE1_LOW)) begin
				next_st.reg_rdata = st.compare1_pair[7:0];
			end else if (hit(reg_page_dma, reg_addr, 1'b0, `OFS_TIMER_CONTROL)) begin
				next_st.reg_rdata = {st.timer_control, timer_status};
			end else if (hit(reg_page_dma, reg_addr, 1'b0, `OFS_TIMER_FLAG)) begin
				next_st.reg_rdata = {4'h0, st.timer_flag_reg};
			end else if (hit(reg_page_dma, reg_addr, 1'b0, `OFS_INT_DMA_MASK)) begin
				next_st.reg_rdata = st.int_dma_mask_reg;
			end else if (hit(reg_page_dma, reg_addr, 1'b1, `OFS_COUNTER_POINTER_BASE)) begin
				next_st.reg_rdata = st.counter_pointer_base;
			end else if (hit(reg_page_dma, reg_addr, 1'b1, `OFS_ADDRESS_POINTER_BASE)) begin
				next_st.reg_rdata = st.address_pointer_base;
			end else if (hit(reg_page_dma, reg_addr, 1'b1, `OFS_INT_DMA_CONTROL)) begin
				next_st.reg_rdata = st.int_dma_control_reg;
			end
		end
	end

	// ==========================================
	// State register
	always_ff @(posedge clk) begin
		if (rst) begin
			st <= '0;
			st.timer_control <= `RESET_CONTROL_HIGH;
			st.irq_prio <= `PRIO_COMPARE;
		end else begin
			st <= next_st;
		end
	end

	// ==========================================
	// Outputs
	assign reg_rdata = st.reg_rdata;
	assign dma_req = st.dma_req;
	assign dma_prio = st.dma_prio;
	assign dma_chan_cap = st.chan_cap;
	assign dma_to_mem = st.dma_to_mem;
	assign dma_byte_mode = ~st.word;
	assign dma_cnt_ptr = st.dma_cnt_ptr;
	assign dma_addr_ptr = st.dma_addr_ptr;
	assign dma_rdata = st.dma_rdata;
	assign irq_req = st.irq_req;
	assign irq_prio = st.irq_prio;
	assign port_strobe = st.port_strobe;
	assign port_event_pulse = st.port_event_pulse;
	assign port_sync = st.port_sync;
	assign port_data = st.port_data;
	assign compare0_value = st.compare0_pair;
	assign compare1_value = st.compare1_pair;
	assign load0_value = st.capture_load0_pair;
	assign load1_value = st.capture_load1_pair;
	assign timer_control_bits = st.timer_control;

	// ==========================================
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	AST_WORD_TWO_BYTES: assert property (st.phase == PH_BYTE_FIRST && st.word && dma_ack |=>
		st.phase == PH_BYTE_SECOND && dma_req) else $error("word did not go to second byte");
	AST_SECOND_TOP: assert property (st.phase == PH_BYTE_SECOND |-> dma_prio == 3'h0)
		else $error("second byte not at top priority");
	AST_FIRST_PROGRAMMED: assert property (st.phase == PH_BYTE_FIRST |->
		dma_prio == st.int_dma_control_reg[2:0]) else $error("first byte priority not programmed level");
	AST_CHAN_HELD: assert property (st.phase == PH_BYTE_FIRST && !dma_ack |=>
		$stable(dma_chan_cap)) else $error("channel changed inside a word");
	AST_EOB_SET: assert property (fin_eob && !st.chan_cap |=> st.int_dma_control_reg[6])
		else $error("end of block flag not set");
	AST_SWAP: assert property (fin_eob && st.chan_cap && st.int_dma_control_reg[3] |=>
		st.address_pointer_base[2] != $past(st.address_pointer_base[2])) else $error("swap bit not toggled");
	AST_PROTECT: assert property (fin_eob && !st.chan_cap && st.int_dma_control_reg[6] |=>
		!st.int_dma_mask_reg[0]) else $error("mask not cleared on second end of block");
	AST_EXT_BYTE: assert property (st.phase == PH_BYTE_FIRST && !st.word && dma_ack |=>
		st.phase != PH_BYTE_SECOND) else $error("external mode moved a second byte");
	AST_CAP_FIRST: assert property (st.phase == PH_IDLE && st.timer_flag_reg[1] &&
		st.int_dma_mask_reg[1] |=> dma_req && dma_chan_cap) else $error("capture channel not served first");
	AST_OVERRUN: assert property (compare_zero_event && st.timer_flag_reg[0] |=>
		st.timer_flag_reg[2]) else $error("overrun not flagged");
	AST_IRQ_NO_DMA: assert property (irq_req |-> !dma_req) else $error("interrupt with DMA request");
	AST_STROBE: assert property (st.phase == PH_BYTE_FIRST && !st.word && !st.chan_cap && dma_ack |=>
		port_strobe && port_data == $past(dma_wdata)) else $error("port strobe missing");

	COV_WORD: cover property (st.phase == PH_BYTE_SECOND && dma_ack);
	COV_EOB: cover property (fin_eob);
	COV_PROTECT: cover property (fin_eob && st.int_dma_control_reg[7] && st.chan_cap);
	COV_EXT: cover property (port_strobe);
endmodule // timer_dma_channels

// ===== rtl/timer_dma_map.svh
// Register offsets, field positions, reset values and priority codes of the timer DMA block
`ifndef TIMER_DMA_MAP_SVH
`define TIMER_DMA_MAP_SVH
// ==========================================
// Timer page offsets
`define OFS_CAPTURE_LOAD0_HIGH 8'hf0
`define OFS_CAPTURE_LOAD0_LOW 8'hf1
`define OFS_CAPTURE_LOAD1_HIGH 8'hf2
`define OFS_CAPTURE_LOAD1_LOW 8'hf3
`define OFS_COMPARE0_HIGH 8'hf4
`define OFS_COMPARE0_LOW 8'hf5
`define OFS_COMPARE1_HIGH 8'hf6
`define OFS_COMPARE1_LOW 8'hf7
`define OFS_TIMER_CONTROL 8'hf8
`define OFS_TIMER_FLAG 8'hfe
`define OFS_INT_DMA_MASK 8'hff
// ==========================================
// DMA page offsets
`define OFS_COUNTER_POINTER_BASE 8'hf0
`define OFS_ADDRESS_POINTER_BASE 8'hf1
`define OFS_INT_DMA_CONTROL 8'hf3
// ==========================================
// Interrupt/DMA control fields
`define CTL_EOB_CAP 7
`define CTL_EOB_CMP 6
`define CTL_CAP_EXT 5
`define CTL_CMP_EXT 4
`define CTL_SWAP_EN 3
`define CTL_PRIO_HI 2
// ==========================================
// Interrupt/DMA mask fields
`define MSK_GLOBAL 7
`define MSK_SW_REQ_EN 6
`define MSK_EVENT_PULSE 5
`define MSK_INT_CAP 3
`define MSK_INT_CMP 2
`define MSK_DMA_CAP 1
`define MSK_DMA_CMP 0
// ==========================================
// Flag fields
`define FLG_PEND_CMP 0
`define FLG_PEND_CAP 1
`define FLG_OVR_CMP 2
`define FLG_OVR_CAP 3
// ==========================================
// Pointer fields, priorities, reset values
`define PTR_SWAP_BIT 2
`define PTR_REG_TO_REG 0
`define PRIO_TOP 3'h0
`define PRIO_CAPTURE 3'h4
`define PRIO_COMPARE 3'h6
`define RESET_CONTROL_HIGH 5'h00
`define RESET_BYTE 8'h00
`endif

// ===== rtl/timer_dma_pkg.sv
// Types of the timer DMA block
package timer_dma_pkg;
	typedef enum logic [1:0] {PH_IDLE, PH_BYTE_FIRST, PH_BYTE_SECOND} phase_t;
	typedef struct packed {
		phase_t phase;
		logic chan_cap;
		logic word;
		logic [15:0] capture_load0_pair;
		logic [15:0] capture_load1_pair;
		logic [15:0] compare0_pair;
		logic [15:0] compare1_pair;
		logic [4:0] timer_control;
		logic [7:0] counter_pointer_base;
		logic [7:0] address_pointer_base;
		logic [7:0] int_dma_control_reg;
		logic [7:0] int_dma_mask_reg;
		logic [3:0] timer_flag_reg;
		logic dma_req;
		logic [2:0] dma_prio;
		logic dma_to_mem;
		logic [7:0] dma_cnt_ptr;
		logic [7:0] dma_addr_ptr;
		logic [7:0] dma_rdata;
		logic [7:0] reg_rdata;
		logic irq_req;
		logic [2:0] irq_prio;
		logic port_strobe;
		logic port_event_pulse;
		logic port_sync;
		logic [7:0] port_data;
	} dma_state_t;
endpackage

// ===== sim/core_dma_model.sv
// Behavioural core DMA controller answering the timer DMA requests
module core_dma_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic dma_req,
	input wire logic [3:0] delay,
	input wire logic [3:0] block_bytes,
	output logic dma_ack,
	output logic dma_last,
	output logic [7:0] dma_wdata
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] wait_cnt = 4'h0;
	logic [3:0] byte_n = 4'h0;
	logic [7:0] total = 8'h00;
	initial begin
		dma_ack = 1'b0;
		dma_last = 1'b0;
		dma_wdata = 8'h00;
	end
	// ==========================================
	// One byte per ack, data bus inverted while idle
	always @(posedge clk) begin
		dma_ack <= 1'b0;
		dma_last <= 1'b0;
		dma_wdata <= ~dma_wdata;
		if (rst || !dma_req || dma_ack) begin
			wait_cnt <= 4'h0;
		end else if (wait_cnt < delay) begin
			wait_cnt <= wait_cnt + 4'h1;
		end else begin
			dma_ack <= 1'b1;
			dma_wdata <= 8'h30 + total;
			total <= total + 8'h01;
			dma_last <= (byte_n + 4'h1 == block_bytes);
			byte_n <= (byte_n + 4'h1 == block_bytes) ? 4'h0 : byte_n + 4'h1;
		end
	end
endmodule // core_dma_model

// ===== sim/test_timer_dma_channels.sv
// Self-checking testbench of the timer DMA channels
`include "timer_dma_map.svh"
module test_timer_dma_channels;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, rst = 1'b1, reg_page_dma = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, dma_wdata, dma_cnt_ptr, dma_rdata, port_data;
	logic compare_zero_event = 1'b0, capture_zero_event = 1'b0, capture_one_event = 1'b0;
	logic [15:0] capture_value = 16'h0000, compare0_value, compare1_value, load1_value;
	logic over_under_flow_event = 1'b0, cmp_to_cap_link = 1'b0, port_dma_direction = 1'b0;
	logic [2:0] timer_status = 3'h5, dma_prio, irq_prio;
	logic dma_ack, dma_last, dma_req, dma_chan_cap, dma_to_mem, dma_byte_mode, irq_req;
	logic port_strobe, port_event_pulse, port_sync;
	logic [7:0] dma_addr_ptr;
	logic [15:0] load0_value;
	logic [4:0] timer_control_bits;
	logic [3:0] delay = 4'h2, block_bytes = 4'h4;
	int n_errors = 0, n_compared = 0;
	timer_dma_channels DUT (.clk(clk), .rst(rst), .reg_page_dma(reg_page_dma), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.compare_zero_event(compare_zero_event), .capture_zero_event(capture_zero_event),
		.capture_one_event(capture_one_event), .capture_value(capture_value),
		.over_under_flow_event(over_under_flow_event), .timer_status(timer_status),
		.cmp_to_cap_link(cmp_to_cap_link), .port_dma_direction(port_dma_direction), .dma_ack(dma_ack),
		.dma_last(dma_last), .dma_wdata(dma_wdata), .dma_req(dma_req), .dma_prio(dma_prio),
		.dma_chan_cap(dma_chan_cap), .dma_to_mem(dma_to_mem), .dma_byte_mode(dma_byte_mode),
		.dma_cnt_ptr(dma_cnt_ptr), .dma_addr_ptr(dma_addr_ptr), .dma_rdata(dma_rdata), .irq_req(irq_req),
		.irq_prio(irq_prio), .port_strobe(port_strobe), .port_event_pulse(port_event_pulse),
		.port_sync(port_sync), .port_data(port_data), .compare0_value(compare0_value),
		.compare1_value(compare1_value), .load0_value(load0_value), .load1_value(load1_value),
		.timer_control_bits(timer_control_bits));
	core_dma_model dma_core (.clk(clk), .rst(rst), .dma_req(dma_req), .delay(delay),
		.block_bytes(block_bytes), .dma_ack(dma_ack), .dma_last(dma_last), .dma_wdata(dma_wdata));
	// ==========================================
	// Clock and watchdog
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	initial begin
		repeat (3000) @(posedge clk);
		n_errors++;
		tally_and_finish();
	end
	// ==========================================
	// Tasks
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic pg, input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		reg_page_dma = pg;
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge clk);
		reg_wr = 1'b0;
	endtask
	task automatic rd(input logic pg, input logic [7:0] a, input logic [7:0] e);
		@(negedge clk);
		reg_page_dma = pg;
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge clk);
		reg_rd = 1'b0;
		chk(reg_rdata, e);
	endtask
	task automatic ev(input logic c, input logic p);
		@(negedge clk);
		compare_zero_event = c;
		capture_zero_event = p;
		@(negedge clk);
		compare_zero_event = 1'b0;
		capture_zero_event = 1'b0;
	endtask
	task automatic wreq(input logic lvl);
		for (int i = 0; i < 40 && dma_req !== lvl; i++) @(negedge clk);
		chk(dma_req, lvl);
	endtask
	task automatic wack;
		for (int i = 0; i < 40 && dma_ack !== 1'b1; i++) @(negedge clk);
		chk(dma_ack, 1'b1);
	endtask
	task automatic tally_and_finish;
		$display("errors %0d compared %0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// ==========================================
	// Tests
	initial begin
		repeat (16) @(negedge clk);
		rst = 1'b0;
		rd(0, `OFS_TIMER_CONTROL, 8'h05);
		wr(0, `OFS_TIMER_CONTROL, 8'hff);
		rd(0, `OFS_TIMER_CONTROL, 8'hfd);
		chk(timer_control_bits, 5'h1f);
		rd(0, 8'h00, 8'h00);
		wr(0, `OFS_COMPARE1_HIGH, 8'h12);
		wr(0, `OFS_COMPARE1_LOW, 8'h34);
		chk(compare1_value, 16'h1234);
		capture_value = 16'hbeef;
		capture_one_event = 1'b1;
		@(negedge clk);
		capture_one_event = 1'b0;
		chk(load1_value, 16'hbeef);
		// Word moves, priorities and pointers
		wr(1, `OFS_COUNTER_POINTER_BASE, 8'h14);
		wr(1, `OFS_ADDRESS_POINTER_BASE, 8'h08);
		wr(1, `OFS_INT_DMA_CONTROL, 8'h0d);
		wr(0, `OFS_INT_DMA_MASK, 8'h8f);
		capture_value = 16'h5a6b;
		ev(1, 0);
		wreq(1);
		chk(dma_prio, 3'h5);
		chk({dma_chan_cap, dma_byte_mode, dma_cnt_ptr[2:1]}, 4'b0011);
		chk(dma_addr_ptr, 8'h0e);
		wack();
		ev(0, 1);
		chk(dma_prio, 3'h0);
		wack();
		chk(dma_chan_cap, 1'b0);
		wreq(0);
		chk(compare0_value, 16'h3031);
		wreq(1);
		chk({dma_chan_cap, dma_to_mem, dma_cnt_ptr[2:1]}, 4'b1100);
		chk(dma_addr_ptr, 8'h08);
		chk({dma_prio, dma_rdata}, {3'h5, 8'h5a});
		wreq(0);
		rd(1, `OFS_ADDRESS_POINTER_BASE, 8'h0c);
		rd(1, `OFS_COUNTER_POINTER_BASE, 8'h14);
		rd(1, `OFS_INT_DMA_CONTROL, 8'h8d);
		rd(0, `OFS_CAPTURE_LOAD0_HIGH, 8'h5a);
		chk(load0_value, 16'h5a6b);
		chk({irq_req, irq_prio}, 4'b1100);
		over_under_flow_event = 1'b1;
		repeat (2) @(negedge clk);
		chk(irq_req, 1'b0);
		over_under_flow_event = 1'b0;
		// Both channels at once, then a second block end while flagged
		block_bytes = 4'h2;
		ev(1, 1);
		wreq(1);
		chk(dma_chan_cap, 1'b1);
		wreq(0);
		wreq(1);
		chk(dma_chan_cap, 1'b0);
		wreq(0);
		chk(compare0_value, 16'h3637);
		rd(0, `OFS_INT_DMA_MASK, 8'h8d);
		rd(1, `OFS_COUNTER_POINTER_BASE, 8'h10);
		rd(1, `OFS_ADDRESS_POINTER_BASE, 8'h08);
		// Software written block-end flags
		wr(1, `OFS_INT_DMA_CONTROL, 8'h0d);
		wr(0, `OFS_INT_DMA_MASK, 8'h8c);
		wr(1, `OFS_INT_DMA_CONTROL, 8'h4d);
		rd(1, `OFS_INT_DMA_CONTROL, 8'h0d);
		wr(0, `OFS_INT_DMA_MASK, 8'hcc);
		wr(1, `OFS_INT_DMA_CONTROL, 8'h4d);
		@(negedge clk);
		chk({irq_req, irq_prio}, 4'b1110);
		// Events without DMA mask and overrun
		ev(1, 0);
		ev(1, 0);
		rd(0, `OFS_TIMER_FLAG, 8'h05);
		chk(dma_req, 1'b0);
		// Compare external mode to the port
		wr(0, `OFS_TIMER_FLAG, 8'h00);
		wr(1, `OFS_INT_DMA_CONTROL, 8'h15);
		wr(0, `OFS_INT_DMA_MASK, 8'h21);
		block_bytes = 4'h1;
		delay = 4'h0;
		ev(1, 0);
		wreq(1);
		chk(dma_byte_mode, 1'b1);
		wack();
		@(negedge clk);
		chk({port_strobe, port_event_pulse, port_data}, 10'h338);
		wreq(0);
		wr(0, `OFS_TIMER_FLAG, 8'h01);
		wack();
		@(negedge clk);
		chk({port_strobe, port_data}, 9'h139);
		// Capture external mode, then compare events linked into capture
		wr(1, `OFS_INT_DMA_CONTROL, 8'h25);
		wr(0, `OFS_INT_DMA_MASK, 8'h02);
		wr(0, `OFS_TIMER_FLAG, 8'h02);
		wreq(1);
		chk({dma_chan_cap, dma_byte_mode, dma_to_mem}, 3'b110);
		wack();
		@(negedge clk);
		chk(port_sync, 1'b1);
		wreq(0);
		wr(0, `OFS_INT_DMA_MASK, 8'h00);
		cmp_to_cap_link = 1'b1;
		ev(1, 0);
		rd(0, `OFS_TIMER_FLAG, 8'h03);
		tally_and_finish();
	end
endmodule // test_timer_dma_channels
